// [pkg/pat_params.svh]
// Purpose: constants for the prescaled auto-reload timer block
// Assumes: byte-wide special function register port, one clock
// Notes: offsets, field positions, reset values, divider counts
//
// Operation
// R01: prescale select 00/01/10/11 gives core clock /12, /4, /48, external /8.
// R02: external oscillator over eight is synchronised to the core clock first.
// R03: timer0 count low and high bytes are read/write, zero after reset.
// R04: timer2 is two 8-bit registers; control bit 3 selects split mode. Here split mode is only stored, and the counter holds while bit 3 is set.
// R05: with split mode clear, timer2 is one 16-bit auto-reload up-counter.
// R06: timer2 counts core clock, core clock /12 or external clock /8.
// R07: on rollover from ffff the reload pair is loaded instead of zero.
// R08: each 16-bit rollover sets the high overflow flag, control bit 7.
// R09: with interrupt enable t2_irq_enable set, each 16-bit overflow raises an irq.
// R10: with low byte irq enable also set, low byte rollover raises an irq.
// R11: hardware never clears either overflow flag; software clears by writing.
// R12: low overflow flag sets whenever the low byte rolls from ff.
// R13: low byte clock select picks core clock, else external select chooses.
// R14: high byte increments on the edge where the low byte rolls over.
`ifndef PAT_PARAMS_SVH
`define PAT_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PAT_ADDR_T0L 8'h8a
`define PAT_ADDR_T0H 8'h8c
`define PAT_ADDR_CKC 8'h8e
`define PAT_ADDR_T2C 8'hc8
`define PAT_ADDR_RLL 8'hca
`define PAT_ADDR_RLH 8'hcb
`define PAT_ADDR_T2L 8'hcc
`define PAT_ADDR_T2H 8'hcd

// ----------------------------------------
// field positions
// ----------------------------------------
`define PAT_T2C_HOF 7
`define PAT_T2C_LOF 6
`define PAT_T2C_LIE 5
`define PAT_T2C_SPLIT 3
`define PAT_T2C_RUN 2
`define PAT_T2C_XCLK 0
`define PAT_CKC_LOW_BYTE_CLOCK_SELECT 4
`define PAT_T2C_RMASK 8'hed

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define PAT_RST_BYTE 8'h00
`define PAT_RST_CNT 16'h0000
`define PAT_CNT_MAX 16'hffff
`define PAT_BYTE_MAX 8'hff
`define PAT_DIV4 6'h04
`define PAT_DIV12 6'h0c
`define PAT_DIV48 6'h30
`define PAT_EXT_LAST 3'h7

`endif

// [pkg/pat_pkg.sv]
// Purpose: types shared by the timer block
// Assumes: nothing beyond the params header
// Notes: sfr request travels as one packed struct
`default_nettype none
package pat_pkg;
  typedef enum logic [1:0]
  {
    PAT_PS_DIV12 = 2'h0,
    PAT_PS_DIV4 = 2'h1,
    PAT_PS_DIV48 = 2'h2,
    PAT_PS_EXT8 = 2'h3
  } pat_presc_t;

  typedef struct packed
  {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pat_sfr_req_t;
endpackage
`default_nettype wire

// [rtl/pat_ext_div8.sv]
// Purpose: external oscillator synchroniser and divide-by-eight
// Assumes: oscillator slower than half the core clock
// Notes: one-cycle tick per eight external rising edges
`include "pat_params.svh"
`default_nettype none
module pat_ext_div8
  import pat_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ext_osc,
  output logic ext_tick
);
  logic meta_r, sync_r, last_r, tick_r;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic rise, tick_nxt;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    rise = sync_r & ~last_r;
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (rise)
    begin
      cnt_nxt = cnt_r + 3'h1;
      tick_nxt = (cnt_r == `PAT_EXT_LAST);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // meta_r feeds sync_r only, nothing else reads it
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      cnt_r <= 3'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      meta_r <= ext_osc; // [R02]
      sync_r <= meta_r; // [R02]
      last_r <= sync_r;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign ext_tick = tick_r;

  a_ext_div_eight: assert property ( // [R02]
    @(posedge clk) disable iff (!nrst)
    tick_r |-> $past(cnt_r) == `PAT_EXT_LAST &&
    $past(sync_r) && !$past(last_r))
    else $error("external tick not on eighth synced edge");
endmodule
`default_nettype wire

// [rtl/pat_prescaler.sv]
// Purpose: shared core clock dividers and legacy prescale select
// Assumes: ext_tick already in the core clock domain
// Notes: one free-running mod-48 counter serves /4, /12 and /48
`include "pat_params.svh"
`default_nettype none
module pat_prescaler
  import pat_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire pat_presc_t sel,
  input wire logic ext_tick,
  output logic div12_tick,
  output logic presc_tick
);
  logic [5:0] cnt_r, cnt_nxt;
  logic d12_r, d12_nxt, ps_r, ps_nxt;

  function automatic logic at_last(input logic [5:0] c,
                                   input logic [5:0] div);
    at_last = ((c % div) == (div - 6'h01));
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    cnt_nxt = at_last(cnt_r, `PAT_DIV48) ? 6'h00 : cnt_r + 6'h01;
    d12_nxt = at_last(cnt_r, `PAT_DIV12);
    unique case (sel) // [R01]
      PAT_PS_DIV12: ps_nxt = at_last(cnt_r, `PAT_DIV12);
      PAT_PS_DIV4: ps_nxt = at_last(cnt_r, `PAT_DIV4);
      PAT_PS_DIV48: ps_nxt = at_last(cnt_r, `PAT_DIV48);
      PAT_PS_EXT8: ps_nxt = ext_tick;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_r <= 6'h00;
      d12_r <= 1'b0;
      ps_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      d12_r <= d12_nxt;
      ps_r <= ps_nxt;
    end
  end

  assign div12_tick = d12_r;
  assign presc_tick = ps_r;

  a_presc_div48: assert property ( // [R01]
    @(posedge clk) disable iff (!nrst)
    $past(sel) == PAT_PS_DIV48 && ps_r |-> $past(cnt_r) == 6'h2f)
    else $error("divide by 48 tick at wrong count");
  a_presc_div4: assert property ( // [R01]
    @(posedge clk) disable iff (!nrst)
    $past(sel) == PAT_PS_DIV4 |-> ps_r == ($past(cnt_r[1:0]) == 2'h3))
    else $error("divide by 4 tick wrong");
endmodule
`default_nettype wire

// [rtl/pat_top.sv]
// Purpose: timer0 count bytes, shared prescaler, 16-bit reload timer2
// Assumes: sfr port on core clock; rdata valid the cycle after rd
// Notes: split 8-bit mode only stored; timer2 holds while it is set
`include "pat_params.svh"
`default_nettype none
module pat_top
  import pat_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire pat_sfr_req_t sfr,
  output logic [7:0] sfr_rdata,
  input wire logic t2_irq_enable,
  input wire logic ext_osc,
  output logic t01_presc_tick,
  output logic t2_irq
);
  // ----------------------------------------
  // registers and next values
  // ----------------------------------------
  logic [7:0] t0l_r, t0l_nxt, t0h_r, t0h_nxt;
  logic [7:0] ckc_r, ckc_nxt, t2c_r, t2c_nxt;
  logic [7:0] rll_r, rll_nxt, rlh_r, rlh_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic irq_r, irq_nxt;
  logic ext_tick, div12_tick;
  logic t2_tick, count_en, low_ovf, high_ovf;
  logic wr_t2c, wr_t2l, wr_t2h;

  function automatic logic hit(input pat_sfr_req_t q,
                               input logic [7:0] a);
    hit = q.wr && (q.addr == a);
  endfunction

  // ----------------------------------------
  // clock sources
  // ----------------------------------------
  pat_ext_div8 u_ext
  (
    .clk(clk),
    .nrst(nrst),
    .ext_osc(ext_osc),
    .ext_tick(ext_tick)
  );

  pat_prescaler u_presc
  (
    .clk(clk),
    .nrst(nrst),
    .sel(pat_presc_t'(ckc_r[1:0])),
    .ext_tick(ext_tick),
    .div12_tick(div12_tick),
    .presc_tick(t01_presc_tick)
  );

  // ----------------------------------------
  // timer2 count enable
  // ----------------------------------------
  always_comb
  begin
    if (ckc_r[`PAT_CKC_LOW_BYTE_CLOCK_SELECT]) // [R13]
      t2_tick = 1'b1; // [R06]
    else if (t2c_r[`PAT_T2C_XCLK]) // [R13]
      t2_tick = ext_tick; // [R06]
    else
      t2_tick = div12_tick; // [R06]
    // split mode is not built, so the counter simply holds there
    count_en = t2_tick && t2c_r[`PAT_T2C_RUN] &&
               !t2c_r[`PAT_T2C_SPLIT]; // [R04] [R05]
    low_ovf = count_en && (cnt_r[7:0] == `PAT_BYTE_MAX);
    high_ovf = count_en && (cnt_r == `PAT_CNT_MAX);
  end

  // ----------------------------------------
  // register file and counter
  // ----------------------------------------
  always_comb
  begin
    wr_t2c = hit(sfr, `PAT_ADDR_T2C);
    wr_t2l = hit(sfr, `PAT_ADDR_T2L);
    wr_t2h = hit(sfr, `PAT_ADDR_T2H);
    t0l_nxt = hit(sfr, `PAT_ADDR_T0L) ? sfr.wdata : t0l_r; // [R03]
    t0h_nxt = hit(sfr, `PAT_ADDR_T0H) ? sfr.wdata : t0h_r; // [R03]
    ckc_nxt = hit(sfr, `PAT_ADDR_CKC) ? sfr.wdata : ckc_r;
    rll_nxt = hit(sfr, `PAT_ADDR_RLL) ? sfr.wdata : rll_r;
    rlh_nxt = hit(sfr, `PAT_ADDR_RLH) ? sfr.wdata : rlh_r;
    t2c_nxt = wr_t2c ? (sfr.wdata & `PAT_T2C_RMASK) : t2c_r;
    // flags are cleared only by a software write; a set wins [R11]
    if (high_ovf)
      t2c_nxt[`PAT_T2C_HOF] = 1'b1; // [R08]
    if (low_ovf)
      t2c_nxt[`PAT_T2C_LOF] = 1'b1; // [R12]
    cnt_nxt = cnt_r;
    if (high_ovf)
      cnt_nxt = {rlh_r, rll_r}; // [R07]
    else if (count_en)
      cnt_nxt = cnt_r + 16'h0001; // [R05] [R14]
    // a software write to a count byte beats the tick in that cycle
    if (wr_t2l)
      cnt_nxt[7:0] = sfr.wdata;
    if (wr_t2h)
      cnt_nxt[15:8] = sfr.wdata;
    irq_nxt = t2_irq_enable && (t2c_nxt[`PAT_T2C_HOF] ||
              (t2c_nxt[`PAT_T2C_LIE] && t2c_nxt[`PAT_T2C_LOF])); // [R09] [R10]
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb
  begin
    rd_nxt = rd_r;
    if (sfr.rd)
    begin
      unique case (sfr.addr)
        `PAT_ADDR_T0L: rd_nxt = t0l_r;
        `PAT_ADDR_T0H: rd_nxt = t0h_r;
        `PAT_ADDR_CKC: rd_nxt = ckc_r;
        `PAT_ADDR_T2C: rd_nxt = t2c_r;
        `PAT_ADDR_RLL: rd_nxt = rll_r;
        `PAT_ADDR_RLH: rd_nxt = rlh_r;
        `PAT_ADDR_T2L: rd_nxt = cnt_r[7:0];
        `PAT_ADDR_T2H: rd_nxt = cnt_r[15:8];
        default: rd_nxt = `PAT_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      t0l_r <= `PAT_RST_BYTE; // [R03]
      t0h_r <= `PAT_RST_BYTE; // [R03]
      ckc_r <= `PAT_RST_BYTE;
      t2c_r <= `PAT_RST_BYTE;
      rll_r <= `PAT_RST_BYTE;
      rlh_r <= `PAT_RST_BYTE;
      cnt_r <= `PAT_RST_CNT;
      rd_r <= `PAT_RST_BYTE;
      irq_r <= 1'b0;
    end
    else
    begin
      t0l_r <= t0l_nxt;
      t0h_r <= t0h_nxt;
      ckc_r <= ckc_nxt;
      t2c_r <= t2c_nxt;
      rll_r <= rll_nxt;
      rlh_r <= rlh_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign sfr_rdata = rd_r;
  assign t2_irq = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_t0_reset_zero: assert property ( // [R03]
    @(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> t0l_r == 8'h00 && t0h_r == 8'h00)
    else $error("timer0 bytes not zero after reset");

  a_split_holds: assert property ( // [R04]
    @(posedge clk) disable iff (!nrst)
    t2c_r[`PAT_T2C_SPLIT] && !wr_t2l && !wr_t2h |=> $stable(cnt_r))
    else $error("counter moved in split mode");

  a_count_step: assert property ( // [R05]
    @(posedge clk) disable iff (!nrst)
    count_en && cnt_r != 16'hffff && !wr_t2l && !wr_t2h
    |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("16-bit count did not step by one");

  a_clock_select: assert property ( // [R06]
    @(posedge clk) disable iff (!nrst)
    !ckc_r[`PAT_CKC_LOW_BYTE_CLOCK_SELECT] && !t2c_r[`PAT_T2C_XCLK] && t2_tick
    |-> div12_tick)
    else $error("timer2 tick not from divide by 12");

  a_reload_load: assert property ( // [R07]
    @(posedge clk) disable iff (!nrst)
    high_ovf && !wr_t2l && !wr_t2h |=> cnt_r == {$past(rlh_r), $past(rll_r)})
    else $error("reload value not loaded on rollover");

  a_high_flag_set: assert property ( // [R08]
    @(posedge clk) disable iff (!nrst)
    high_ovf |=> t2c_r[`PAT_T2C_HOF] && (t2_irq || !$past(t2_irq_enable)))
    else $error("high overflow flag not set");

  a_irq_high: assert property ( // [R09]
    @(posedge clk) disable iff (!nrst)
    t2_irq_enable && t2c_r[`PAT_T2C_HOF] && $stable(t2_irq_enable)
    |-> t2_irq)
    else $error("no interrupt on high overflow");

  a_irq_low: assert property ( // [R10]
    @(posedge clk) disable iff (!nrst)
    $past(t2_irq_enable) && t2c_r[`PAT_T2C_LIE] && t2c_r[`PAT_T2C_LOF]
    |-> t2_irq)
    else $error("no interrupt on low overflow");

  a_flags_sticky: assert property ( // [R11]
    @(posedge clk) disable iff (!nrst)
    t2c_r[`PAT_T2C_HOF] && !wr_t2c |=> t2c_r[`PAT_T2C_HOF])
    else $error("high flag cleared without a write");

  a_low_flag_set: assert property ( // [R12]
    @(posedge clk) disable iff (!nrst)
    low_ovf |=> t2c_r[`PAT_T2C_LOF])
    else $error("low overflow flag not set");

  a_core_clock: assert property ( // [R13]
    @(posedge clk) disable iff (!nrst)
    ckc_r[`PAT_CKC_LOW_BYTE_CLOCK_SELECT] && t2c_r[`PAT_T2C_RUN] && !t2c_r[`PAT_T2C_SPLIT]
    && cnt_r != 16'hffff && !wr_t2l && !wr_t2h
    |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("core clock select did not count every cycle");

  a_carry_chain: assert property ( // [R14]
    @(posedge clk) disable iff (!nrst)
    low_ovf && !high_ovf && !wr_t2h && !wr_t2l
    |=> cnt_r[15:8] == $past(cnt_r[15:8]) + 8'h01 && cnt_r[7:0] == 8'h00)
    else $error("high byte missed the carry");

  a_low_flag_sticky: assert property ( // [R11]
    @(posedge clk) disable iff (!nrst)
    t2c_r[`PAT_T2C_LOF] && !wr_t2c |=> t2c_r[`PAT_T2C_LOF])
    else $error("low flag cleared without a write");

  a_flag_clear_write: assert property ( // [R11]
    @(posedge clk) disable iff (!nrst)
    wr_t2c && !sfr.wdata[`PAT_T2C_HOF] && !high_ovf |=> !t2c_r[`PAT_T2C_HOF])
    else $error("software clear of high flag lost");

  a_high_flag_cause: assert property ( // [R08]
    @(posedge clk) disable iff (!nrst)
    !t2c_r[`PAT_T2C_HOF] && !high_ovf && !wr_t2c |=> !t2c_r[`PAT_T2C_HOF])
    else $error("high flag set with no overflow");

  a_low_flag_cause: assert property ( // [R12]
    @(posedge clk) disable iff (!nrst)
    !t2c_r[`PAT_T2C_LOF] && !low_ovf && !wr_t2c |=> !t2c_r[`PAT_T2C_LOF])
    else $error("low flag set with no overflow");

  a_run_off_holds: assert property ( // [R05]
    @(posedge clk) disable iff (!nrst)
    !t2c_r[`PAT_T2C_RUN] && !wr_t2l && !wr_t2h |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  a_count_write_wins: assert property ( // [R04]
    @(posedge clk) disable iff (!nrst)
    wr_t2l |=> cnt_r[7:0] == $past(sfr.wdata))
    else $error("low count byte write lost");

  a_t0_low_write: assert property ( // [R03]
    @(posedge clk) disable iff (!nrst)
    sfr.wr && sfr.addr == `PAT_ADDR_T0L |=> t0l_r == $past(sfr.wdata))
    else $error("timer0 low byte write lost");

  a_t0_high_write: assert property ( // [R03]
    @(posedge clk) disable iff (!nrst)
    sfr.wr && sfr.addr == `PAT_ADDR_T0H |=> t0h_r == $past(sfr.wdata))
    else $error("timer0 high byte write lost");

  a_irq_quiet: assert property ( // [R09]
    @(posedge clk) disable iff (!nrst)
    !$past(t2_irq_enable) |-> !t2_irq)
    else $error("interrupt while timer2 interrupts disabled");

  a_irq_needs_lie: assert property ( // [R10]
    @(posedge clk) disable iff (!nrst)
    !t2c_r[`PAT_T2C_HOF] && !t2c_r[`PAT_T2C_LIE] |-> !t2_irq)
    else $error("low overflow interrupt without its enable");

  // ----------------------------------------
  // divide-by-12 spacing watch
  // ----------------------------------------
  // the select mux alone proves nothing, so the tick gap is measured
  logic [5:0] gap_r, gap_nxt;
  logic seen_r, seen_nxt;

  always_comb
  begin
    seen_nxt = seen_r || div12_tick;
    if (div12_tick)
      gap_nxt = 6'h01;
    else if (gap_r == 6'h3f)
      gap_nxt = gap_r;
    else
      gap_nxt = gap_r + 6'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gap_r <= 6'h00;
      seen_r <= 1'b0;
    end
    else
    begin
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end

  a_div12_spacing: assert property ( // [R06]
    @(posedge clk) disable iff (!nrst)
    seen_r && div12_tick |-> gap_r == `PAT_DIV12)
    else $error("divide by 12 ticks not twelve cycles apart");

  a_div12_no_gap: assert property ( // [R06]
    @(posedge clk) disable iff (!nrst)
    seen_r |-> gap_r <= `PAT_DIV12)
    else $error("divide by 12 tick missing");
endmodule
`default_nettype wire

// [tb/tb_prescaled_autoreload_timers.sv]
// Purpose: self-checking bench for the prescaled auto-reload timer block
// Assumes: sfr strobes driven at the falling edge, one access at a time
// Notes: count windows carry up to three counts of slack for write latency
`include "pat_params.svh"
`default_nettype none
module tb_prescaled_autoreload_timers
  import pat_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ext_osc = 1'b0;
  logic t2_irq_enable = 1'b0;
  pat_sfr_req_t sfr = '0;
  logic [7:0] sfr_rdata;
  logic t01_presc_tick;
  logic t2_irq;
  int n_fail = 0;
  int comparisons = 0;
  int cnt;
  logic [7:0] rd_v;
  logic [23:0] rows [9];

  always #2 clk = ~clk;
  // oscillator runs free, phase unrelated to clk
  always #18.5 ext_osc = ~ext_osc;

  pat_top u_dut (.clk(clk), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .t2_irq_enable(t2_irq_enable), .ext_osc(ext_osc),
    .t01_presc_tick(t01_presc_tick), .t2_irq(t2_irq));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1'b1;
    @(negedge clk);
    sfr.wr = 1'b0;
  endtask

  // rdata is sampled a cycle late; it holds until the next read
  task automatic sfr_rd(input logic [7:0] a);
    @(negedge clk);
    sfr.addr = a;
    sfr.rd = 1'b1;
    @(negedge clk);
    sfr.rd = 1'b0;
    @(negedge clk);
    rd_v = sfr_rdata;
  endtask

  task automatic count_ticks(input int n);
    cnt = 0;
    repeat (n)
    begin
      @(negedge clk);
      if (t01_presc_tick === 1'b1)
        cnt++;
    end
  endtask

  function automatic logic [7:0] in_rng(input int v, input int lo,
                                        input int hi);
    return {7'h00, (v >= lo && v <= hi)};
  endfunction

  // counts from zero for about n cycles, then stops and reads the low byte
  task automatic t2_run(input logic [7:0] ctl, input int n);
    sfr_wr(`PAT_ADDR_T2L, 8'h00);
    sfr_wr(`PAT_ADDR_T2H, 8'h00);
    sfr_wr(`PAT_ADDR_T2C, ctl);
    repeat (n) @(negedge clk);
    sfr_wr(`PAT_ADDR_T2C, 8'h00);
    sfr_rd(`PAT_ADDR_T2L);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rows = '{{`PAT_ADDR_T0L, 8'ha5, 8'ha5}, {`PAT_ADDR_T0H, 8'h5a, 8'h5a},
      {`PAT_ADDR_CKC, 8'h13, 8'h13}, {`PAT_ADDR_RLL, 8'h3c, 8'h3c},
      {`PAT_ADDR_RLH, 8'hc3, 8'hc3}, {`PAT_ADDR_T2L, 8'h5a, 8'h5a},
      {`PAT_ADDR_T2H, 8'ha5, 8'ha5}, {8'h80, 8'h77, 8'h00},
      {`PAT_ADDR_T2C, 8'hff, 8'hed}};
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i])
    begin
      sfr_wr(rows[i][23:16], rows[i][15:8]);
      sfr_rd(rows[i][23:16]);
      check(rd_v, rows[i][7:0]);
    end
    $display("done: register rows");
    // second reset in mid-run must clear what the rows left behind
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i])
    begin
      sfr_rd(rows[i][23:16]);
      check(rd_v, 8'h00);
    end
    $display("done: reset values");
    for (int s = 0; s < 3; s++)
    begin
      sfr_wr(`PAT_ADDR_CKC, 8'(s));
      repeat (4) @(negedge clk);
      count_ticks(480);
      check(8'(cnt), (s == 0) ? 8'h28 : (s == 1) ? 8'h78 : 8'h0a);
    end
    sfr_wr(`PAT_ADDR_CKC, 8'h03);
    repeat (4) @(negedge clk);
    count_ticks(740);
    check(in_rng(cnt, 9, 11), 8'h01);
    $display("done: prescaler");
    sfr_wr(`PAT_ADDR_CKC, 8'h00);
    t2_run(8'h04, 480);
    check(in_rng(rd_v, 39, 42), 8'h01);
    t2_run(8'h05, 740);
    check(in_rng(rd_v, 9, 11), 8'h01);
    sfr_wr(`PAT_ADDR_CKC, 8'h10);
    t2_run(8'h04, 100);
    check(in_rng(rd_v, 100, 103), 8'h01);
    $display("done: timer2 clocks");
    t2_irq_enable = 1'b1;
    sfr_wr(`PAT_ADDR_RLL, 8'h34);
    sfr_wr(`PAT_ADDR_RLH, 8'h12);
    sfr_wr(`PAT_ADDR_T2L, 8'hff);
    sfr_wr(`PAT_ADDR_T2H, 8'hff);
    sfr_wr(`PAT_ADDR_T2C, 8'h04);
    repeat (6) @(negedge clk);
    check({7'h00, t2_irq}, 8'h01);
    sfr_rd(`PAT_ADDR_T2C);
    check(rd_v, 8'hc4);
    sfr_rd(`PAT_ADDR_T2H);
    check(rd_v, 8'h12);
    sfr_wr(`PAT_ADDR_T2C, 8'hc0);
    repeat (20) @(negedge clk);
    check({7'h00, t2_irq}, 8'h01);
    t2_irq_enable = 1'b0;
    repeat (3) @(negedge clk);
    check({7'h00, t2_irq}, 8'h00);
    t2_irq_enable = 1'b1;
    sfr_wr(`PAT_ADDR_T2C, 8'h00);
    repeat (3) @(negedge clk);
    check({7'h00, t2_irq}, 8'h00);
    $display("done: 16-bit rollover");
    sfr_wr(`PAT_ADDR_T2L, 8'hfd);
    sfr_wr(`PAT_ADDR_T2H, 8'h00);
    sfr_wr(`PAT_ADDR_T2C, 8'h24);
    repeat (6) @(negedge clk);
    check({7'h00, t2_irq}, 8'h01);
    sfr_rd(`PAT_ADDR_T2C);
    check(rd_v, 8'h64);
    sfr_rd(`PAT_ADDR_T2H);
    check(rd_v, 8'h01);
    sfr_wr(`PAT_ADDR_T2C, 8'h40);
    repeat (3) @(negedge clk);
    check({7'h00, t2_irq}, 8'h00);
    // split mode: the pair must not act as one carry-chained counter
    sfr_wr(`PAT_ADDR_T2H, 8'h00);
    sfr_wr(`PAT_ADDR_T2L, 8'hff);
    sfr_wr(`PAT_ADDR_T2C, 8'h0c);
    repeat (10) @(negedge clk);
    sfr_rd(`PAT_ADDR_T2H);
    check(rd_v, 8'h00);
    sfr_rd(`PAT_ADDR_T2L);
    check(rd_v, 8'hff);
    $display("done: low byte overflow");
    print_verdict();
  end

  // ----------------------------------------
  // watchdog: the sequence needs about 15 us
  // ----------------------------------------
  initial
  begin
    #100000;
    n_fail++;
    $display("ERROR at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
